// ---- common/dfap_defs.svh ----
// register offsets, field positions, reset values and mode codes of the dual-function ports
`ifndef DFAP_DEFS_SVH
`define DFAP_DEFS_SVH
// ============================================================
// register offsets
`define DFAP_OFS_FP_LATCH    4'h0
`define DFAP_OFS_SP_LATCH    4'h1
`define DFAP_OFS_FP_DIR      4'h2
`define DFAP_OFS_SP_DIR      4'h3
`define DFAP_OFS_MEM_MODE    4'h4
`define DFAP_OFS_PULLUP      4'h5
`define DFAP_OFS_BUS_CTRL    4'h6
`define DFAP_OFS_FP_BSET     4'h8
`define DFAP_OFS_FP_BCLR     4'h9
`define DFAP_OFS_SP_BSET     4'ha
`define DFAP_OFS_SP_BCLR     4'hb
// ============================================================
// field positions
`define DFAP_POS_FP_PULLUP   5
`define DFAP_POS_SP_PULLUP   6
`define DFAP_POS_EXT_WAIT    0
`define DFAP_POS_HOLD_EN     1
`define DFAP_POS_REFRESH_EN  2
// ============================================================
// reset values
`define DFAP_RST_DIR         8'hff
`define DFAP_RST_LATCH       8'h00
`define DFAP_RST_MODE        4'h0
`define DFAP_RST_PULLUP      8'h00
`define DFAP_RST_BUS_CTRL    3'h0
// ============================================================
// memory-extension mode codes and first- and second-port address masks
`define DFAP_MODE_A8_9       4'h4
`define DFAP_MODE_A8_11      4'h5
`define DFAP_MODE_A8_13      4'h6
`define DFAP_MODE_A8_15      4'h7
`define DFAP_MODE_A16_17     4'h8
`define DFAP_MODE_A16_19     4'h9
`define DFAP_MASK_A8_9       8'h03
`define DFAP_MASK_A8_11      8'h0f
`define DFAP_MASK_A8_13      8'h3f
`define DFAP_MASK_A8_15      8'hff
`define DFAP_MASK_A16_17     4'h3
`define DFAP_MASK_A16_19     4'hf
`endif

// ---- common/dfap_pkg.sv ----
// types shared by the dual-function port block
package dfap_pkg;
  typedef logic [7:0]  dfap_byte_t;
  typedef logic [3:0]  dfap_addr_t;
  typedef logic [3:0]  dfap_mode_t;
  typedef logic [19:8] dfap_upper_addr_t;
endpackage : dfap_pkg

// ---- src/dfap_ports.sv ----
// two 8-bit ports whose pins double as upper address, strobe, wait, hold and refresh pins
`timescale 1ns/10ps
`include "dfap_defs.svh"
// ============================================================
// Overview of operation
// - each first-port pin is input or output by its own direction bit
// - first-port pins move to address use in 2-bit groups by mode field
// - codes 0000/0011 all port; 0100..0111 give address 8-9 up to 8-15
// - an output latch keeps its value until the next write to it
// - output-mode reads return the latch; full and read-modify-write updates accepted
// - input-mode reads return the pin level
// - port writes load all eight latches; input pins stay high impedance
// - switching a pin to output drives the value already in its latch
// - an input-mode latch cannot be read back
// - bit set/clear is an 8-bit read-modify-write of the port
// - address-mode first-port pins carry upper address bits automatically
// - first-port pull-up only when pull-up enable is 1 and the pin's direction bit is input
// - reset makes all second-port pins high-impedance inputs, except pins 0-5 in the reduced variant
// - reduced variant: second-port pins 0-3 output-only, low after reset
// - second-port pins 0-3 become address 16-19 in 2-bit groups
// - second-port pins 4/5 are read/write strobes in extension mode
// - second-port pin 6 is wait input, or hold request when hold enabled
// - second-port pin 7 outputs hold acknowledge or refresh pulses
// - reduced variant: first-port pins are address 8-15 only
// - reset makes all first-port pins high-impedance inputs, except in the reduced variant where they drive address
module dfap_ports #(
  parameter bit REDUCED_VARIANT = 1'b0
) (
  input  logic                       clock,
  input  logic                       srst,
  input  dfap_pkg::dfap_addr_t       addr,
  input  dfap_pkg::dfap_byte_t       wdata,
  input  logic                       wr_en,
  input  logic                       rd_en,
  output dfap_pkg::dfap_byte_t       rdata,
  input  dfap_pkg::dfap_upper_addr_t ext_addr,
  input  logic                       ext_rd_strobe_n,
  input  logic                       ext_wr_strobe_n,
  input  logic                       hold_ack,
  input  logic                       refresh_pulse,
  output logic                       ext_wait_level,
  output logic                       hold_request,
  input  dfap_pkg::dfap_byte_t       first_port_pin_in,
  output dfap_pkg::dfap_byte_t       first_port_pin_out,
  output dfap_pkg::dfap_byte_t       first_port_pin_oe,
  output dfap_pkg::dfap_byte_t       first_port_pullup,
  input  dfap_pkg::dfap_byte_t       second_port_pin_in,
  output dfap_pkg::dfap_byte_t       second_port_pin_out,
  output dfap_pkg::dfap_byte_t       second_port_pin_oe,
  output dfap_pkg::dfap_byte_t       second_port_pullup
);
  import dfap_pkg::*;

  // ============================================================
  // pin synchronisers
  dfap_byte_t fp_sync1;
  dfap_byte_t fp_sync2;
  dfap_byte_t fp_sync3;
  dfap_byte_t fp_level;
  dfap_byte_t sp_sync1;
  dfap_byte_t sp_sync2;
  dfap_byte_t sp_sync3;
  dfap_byte_t sp_level;
  dfap_byte_t next_fp_level;
  dfap_byte_t next_sp_level;

  // a level counts only once the second and third stages agree
  always_comb begin
    next_fp_level = (fp_sync2 & fp_sync3) | ((fp_sync2 ^ fp_sync3) & fp_level);
    next_sp_level = (sp_sync2 & sp_sync3) | ((sp_sync2 ^ sp_sync3) & sp_level);
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      fp_sync1 <= 8'h00;
      fp_sync2 <= 8'h00;
      fp_sync3 <= 8'h00;
      fp_level <= 8'h00;
      sp_sync1 <= 8'h00;
      sp_sync2 <= 8'h00;
      sp_sync3 <= 8'h00;
      sp_level <= 8'h00;
    end else begin
      fp_sync1 <= first_port_pin_in;
      fp_sync2 <= fp_sync1;
      fp_sync3 <= fp_sync2;
      fp_level <= next_fp_level;
      sp_sync1 <= second_port_pin_in;
      sp_sync2 <= sp_sync1;
      sp_sync3 <= sp_sync2;
      sp_level <= next_sp_level;
    end
  end

  // ============================================================
  // registers and pin-function decode
  dfap_byte_t first_port_latch;
  dfap_byte_t second_port_latch;
  dfap_byte_t first_port_direction_reg;
  dfap_byte_t second_port_direction_reg;
  dfap_mode_t memory_extension_mode_reg;
  dfap_byte_t pullup_option_reg;
  logic [2:0] bus_ctrl_reg;
  dfap_byte_t next_first_port_latch;
  dfap_byte_t next_second_port_latch;
  dfap_byte_t next_first_port_direction_reg;
  dfap_byte_t next_second_port_direction_reg;
  dfap_mode_t next_memory_extension_mode_reg;
  dfap_byte_t next_pullup_option_reg;
  logic [2:0] next_bus_ctrl_reg;
  dfap_byte_t next_rdata;

  dfap_byte_t fp_addr_mask;
  dfap_byte_t sp_ctrl_mask;
  dfap_byte_t sp_dir_eff;
  dfap_byte_t fp_read;
  dfap_byte_t sp_read;
  dfap_byte_t bit_sel;
  logic       strobe_mode;
  logic       hold_en;
  logic       refresh_en;
  logic       wait_sel;

  always_comb begin
    case (memory_extension_mode_reg)
      `DFAP_MODE_A8_9:  fp_addr_mask = `DFAP_MASK_A8_9;
      `DFAP_MODE_A8_11: fp_addr_mask = `DFAP_MASK_A8_11;
      `DFAP_MODE_A8_13: fp_addr_mask = `DFAP_MASK_A8_13;
      `DFAP_MODE_A8_15: fp_addr_mask = `DFAP_MASK_A8_15;
      default:          fp_addr_mask = 8'h00;
    endcase
    if (REDUCED_VARIANT) begin
      fp_addr_mask = 8'hff;
    end
    strobe_mode = REDUCED_VARIANT ||
                  (memory_extension_mode_reg >= `DFAP_MODE_A8_9 &&
                   memory_extension_mode_reg <= `DFAP_MODE_A16_19);
    hold_en     = bus_ctrl_reg[`DFAP_POS_HOLD_EN];
    refresh_en  = bus_ctrl_reg[`DFAP_POS_REFRESH_EN];
    // hold request takes the pin over the wait function
    wait_sel    = !hold_en && (bus_ctrl_reg[`DFAP_POS_EXT_WAIT] ||
                               second_port_direction_reg[6]);
    sp_ctrl_mask = 8'h00;
    case (memory_extension_mode_reg)
      `DFAP_MODE_A16_17: sp_ctrl_mask[3:0] = `DFAP_MASK_A16_17;
      `DFAP_MODE_A16_19: sp_ctrl_mask[3:0] = `DFAP_MASK_A16_19;
      default:           sp_ctrl_mask[3:0] = 4'h0;
    endcase
    sp_ctrl_mask[5:4] = {2{strobe_mode}};
    sp_ctrl_mask[6]   = hold_en || bus_ctrl_reg[`DFAP_POS_EXT_WAIT];
    sp_ctrl_mask[7]   = hold_en || refresh_en;
    // reduced variant: low second-port pins are outputs whatever the direction bits say
    sp_dir_eff = REDUCED_VARIANT ? {second_port_direction_reg[7:4], 4'h0}
                                 : second_port_direction_reg;
    // input and control pins show the pin, output pins the latch
    fp_read = (first_port_latch & ~first_port_direction_reg & ~fp_addr_mask) |
              (fp_level & (first_port_direction_reg | fp_addr_mask));
    sp_read = (second_port_latch & ~sp_dir_eff & ~sp_ctrl_mask) |
              (sp_level & (sp_dir_eff | sp_ctrl_mask));
  end

  always_comb begin
    next_first_port_latch          = first_port_latch;
    next_second_port_latch         = second_port_latch;
    next_first_port_direction_reg  = first_port_direction_reg;
    next_second_port_direction_reg = second_port_direction_reg;
    next_memory_extension_mode_reg = memory_extension_mode_reg;
    next_pullup_option_reg         = pullup_option_reg;
    next_bus_ctrl_reg              = bus_ctrl_reg;
    next_rdata                     = 8'h00;
    bit_sel                        = 8'h01 << wdata[2:0];
    if (wr_en) begin
      case (addr)
        `DFAP_OFS_FP_LATCH: next_first_port_latch = wdata;
        `DFAP_OFS_SP_LATCH: next_second_port_latch = wdata;
        `DFAP_OFS_FP_DIR:   next_first_port_direction_reg = wdata;
        `DFAP_OFS_SP_DIR:   next_second_port_direction_reg = wdata;
        `DFAP_OFS_MEM_MODE: next_memory_extension_mode_reg = wdata[3:0];
        `DFAP_OFS_PULLUP:   next_pullup_option_reg = wdata;
        `DFAP_OFS_BUS_CTRL: next_bus_ctrl_reg = wdata[2:0];
        // input bits pick up the pin level read back, as the real port does
        `DFAP_OFS_FP_BSET:  next_first_port_latch = fp_read | bit_sel;
        `DFAP_OFS_FP_BCLR:  next_first_port_latch = fp_read & ~bit_sel;
        `DFAP_OFS_SP_BSET:  next_second_port_latch = sp_read | bit_sel;
        `DFAP_OFS_SP_BCLR:  next_second_port_latch = sp_read & ~bit_sel;
        default: ;
      endcase
    end
    if (rd_en) begin
      case (addr)
        `DFAP_OFS_FP_LATCH: next_rdata = fp_read;
        `DFAP_OFS_SP_LATCH: next_rdata = sp_read;
        `DFAP_OFS_FP_DIR:   next_rdata = first_port_direction_reg;
        `DFAP_OFS_SP_DIR:   next_rdata = second_port_direction_reg;
        `DFAP_OFS_MEM_MODE: next_rdata = {4'h0, memory_extension_mode_reg};
        `DFAP_OFS_PULLUP:   next_rdata = pullup_option_reg;
        `DFAP_OFS_BUS_CTRL: next_rdata = {5'h00, bus_ctrl_reg};
        default:            next_rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      first_port_latch          <= `DFAP_RST_LATCH;
      second_port_latch         <= `DFAP_RST_LATCH;
      first_port_direction_reg  <= `DFAP_RST_DIR;
      second_port_direction_reg <= `DFAP_RST_DIR;
      memory_extension_mode_reg <= `DFAP_RST_MODE;
      pullup_option_reg         <= `DFAP_RST_PULLUP;
      bus_ctrl_reg              <= `DFAP_RST_BUS_CTRL;
      rdata                     <= 8'h00;
    end else begin
      first_port_latch          <= next_first_port_latch;
      second_port_latch         <= next_second_port_latch;
      first_port_direction_reg  <= next_first_port_direction_reg;
      second_port_direction_reg <= next_second_port_direction_reg;
      memory_extension_mode_reg <= next_memory_extension_mode_reg;
      pullup_option_reg         <= next_pullup_option_reg;
      bus_ctrl_reg              <= next_bus_ctrl_reg;
      rdata                     <= next_rdata;
    end
  end

  // ============================================================
  // pin drivers
  dfap_byte_t next_fp_out;
  dfap_byte_t next_fp_oe;
  dfap_byte_t next_fp_pullup;
  dfap_byte_t next_sp_out;
  dfap_byte_t next_sp_oe;
  dfap_byte_t next_sp_pullup;
  logic       next_wait_level;
  logic       next_hold_request;

  always_comb begin
    // address pins follow the bus every cycle, no software involved
    next_fp_out = (first_port_latch & ~fp_addr_mask) |
                  (ext_addr[15:8] & fp_addr_mask);
    next_fp_oe  = ~first_port_direction_reg | fp_addr_mask;
    // pull-ups only for input pins; software must clear the enable in address use
    next_fp_pullup = {8{pullup_option_reg[`DFAP_POS_FP_PULLUP]}} &
                     first_port_direction_reg;
    next_sp_out = second_port_latch;
    next_sp_oe  = ~sp_dir_eff & ~sp_ctrl_mask;
    next_sp_out[3:0] = (second_port_latch[3:0] & ~sp_ctrl_mask[3:0]) |
                       (ext_addr[19:16] & sp_ctrl_mask[3:0]);
    next_sp_oe[3:0]  = next_sp_oe[3:0] | sp_ctrl_mask[3:0];
    if (strobe_mode) begin
      next_sp_out[5:4] = {ext_wr_strobe_n, ext_rd_strobe_n};
      next_sp_oe[5:4]  = 2'b11;
    end
    if (hold_en) begin
      next_sp_out[7] = hold_ack;
      next_sp_oe[7]  = 1'b1;
    end else if (refresh_en) begin
      next_sp_out[7] = refresh_pulse;
      next_sp_oe[7]  = 1'b1;
    end
    next_sp_pullup = {8{pullup_option_reg[`DFAP_POS_SP_PULLUP]}} &
                     second_port_direction_reg;
    if (REDUCED_VARIANT) begin
      next_sp_pullup[3:0] = 4'h0;
    end
    // idle levels: wait released high, hold request low
    next_wait_level   = wait_sel ? sp_level[6] : 1'b1;
    next_hold_request = hold_en && sp_level[6];
  end

  // outputs stay high impedance while reset is held
  always_ff @(posedge clock) begin
    if (srst) begin
      first_port_pin_out  <= 8'h00;
      first_port_pin_oe   <= 8'h00;
      first_port_pullup   <= 8'h00;
      second_port_pin_out <= 8'h00;
      second_port_pin_oe  <= 8'h00;
      second_port_pullup  <= 8'h00;
      ext_wait_level      <= 1'b1;
      hold_request        <= 1'b0;
    end else begin
      first_port_pin_out  <= next_fp_out;
      first_port_pin_oe   <= next_fp_oe;
      first_port_pullup   <= next_fp_pullup;
      second_port_pin_out <= next_sp_out;
      second_port_pin_oe  <= next_sp_oe;
      second_port_pullup  <= next_sp_pullup;
      ext_wait_level      <= next_wait_level;
      hold_request        <= next_hold_request;
    end
  end

  // ============================================================
  // assertions
  default clocking dfap_cb @(posedge clock); endclocking
  default disable iff (srst);

  fp_dir_out_a: assert property (
    (first_port_direction_reg == 8'h00 && fp_addr_mask == 8'h00)
      |=> first_port_pin_oe == 8'hff && first_port_pin_out == $past(first_port_latch))
    else $error("output-mode first-port pins not driving the latch");

  fp_group_addr_a: assert property (
    (!REDUCED_VARIANT && memory_extension_mode_reg == `DFAP_MODE_A8_11 &&
     first_port_direction_reg == 8'hff)
      |=> first_port_pin_oe == 8'h0f && first_port_pin_out[3:0] == $past(ext_addr[11:8]))
    else $error("address group of first port wrong for mode 0101");

  blank_mode_port_a: assert property (
    (!REDUCED_VARIANT && memory_extension_mode_reg == `DFAP_MODE_A16_17 &&
     first_port_direction_reg == 8'hff) |=> first_port_pin_oe == 8'h00)
    else $error("blank mode code drove first-port pins");

  latch_hold_a: assert property (
    !(wr_en && (addr == `DFAP_OFS_FP_LATCH || addr == `DFAP_OFS_FP_BSET ||
                addr == `DFAP_OFS_FP_BCLR)) |=> $stable(first_port_latch))
    else $error("first-port latch changed without a write");

  read_latch_a: assert property (
    (rd_en && addr == `DFAP_OFS_FP_LATCH && first_port_direction_reg == 8'h00 &&
     fp_addr_mask == 8'h00) |=> rdata == $past(first_port_latch))
    else $error("output-mode read did not return the latch");

  read_pin_a: assert property (
    (rd_en && addr == `DFAP_OFS_FP_LATCH && first_port_direction_reg == 8'hff)
      |=> rdata == $past(fp_level))
    else $error("input-mode read did not return the pin level");

  write_all_a: assert property (
    (wr_en && addr == `DFAP_OFS_FP_LATCH && first_port_direction_reg == 8'hff &&
     fp_addr_mask == 8'h00) |=> first_port_latch == $past(wdata) ##1 first_port_pin_oe == 8'h00)
    else $error("input-mode write not latched or reached the pin");

  turn_output_a: assert property (
    (wr_en && addr == `DFAP_OFS_FP_DIR && wdata == 8'h00 && fp_addr_mask == 8'h00)
      ##1 (!wr_en && fp_addr_mask == 8'h00)
      |=> first_port_pin_oe == 8'hff && first_port_pin_out == $past(first_port_latch))
    else $error("latch not driven after switch to output");

  bit_rmw_a: assert property (
    (wr_en && addr == `DFAP_OFS_FP_BSET)
      |=> first_port_latch == ($past(fp_read) | (8'h01 << $past(wdata[2:0]))))
    else $error("bit set was not a read-modify-write of the port");

  fp_pullup_a: assert property (
    ##1 first_port_pullup == ($past(first_port_direction_reg) &
                              {8{$past(pullup_option_reg[`DFAP_POS_FP_PULLUP])}}))
    else $error("first-port pull-up not tied to enable and input mode");

  reset_hiz_a: assert property (
    disable iff (1'b0) srst |=> first_port_pin_oe == 8'h00 && second_port_pin_oe == 8'h00)
    else $error("pins driven while reset held");

  sp_addr_a: assert property (
    (memory_extension_mode_reg == `DFAP_MODE_A16_19)
      |=> second_port_pin_oe[3:0] == 4'hf && second_port_pin_out[3:0] == $past(ext_addr[19:16]))
    else $error("upper address bits 16-19 not on second port");

  strobe_pins_a: assert property (
    strobe_mode |=> second_port_pin_oe[5:4] == 2'b11 &&
                    second_port_pin_out[4] == $past(ext_rd_strobe_n) &&
                    second_port_pin_out[5] == $past(ext_wr_strobe_n))
    else $error("read or write strobe not on second port");

  hold_pins_a: assert property (
    hold_en |=> !second_port_pin_oe[6] && hold_request == $past(sp_level[6]))
    else $error("hold request pin misrouted");

  pin7_func_a: assert property (
    (!hold_en && refresh_en)
      |=> second_port_pin_oe[7] && second_port_pin_out[7] == $past(refresh_pulse))
    else $error("refresh pulse not on pin 7");

endmodule : dfap_ports

// ---- test/dfap_pin_model.sv ----
// external devices on one 8-bit port: drivers, pull-ups and a floating-line pattern
`timescale 1ns/10ps
module dfap_pin_model (
  input  wire logic                 clock,
  input  dfap_pkg::dfap_byte_t      pin_out,
  input  dfap_pkg::dfap_byte_t      pin_oe,
  input  dfap_pkg::dfap_byte_t      pull_en,
  input  dfap_pkg::dfap_byte_t      ext_drv,
  input  dfap_pkg::dfap_byte_t      ext_en,
  output dfap_pkg::dfap_byte_t      pin_in
);
  import dfap_pkg::*;
  // undriven lines without pull-up churn so a stale value never looks right
  dfap_byte_t churn = 8'h55;
  always @(posedge clock) begin
    churn <= ~churn;
  end
  always_comb begin
    pin_in = (pin_oe & pin_out) | (~pin_oe & ext_en & ext_drv)
           | (~pin_oe & ~ext_en & (pull_en | churn));
  end
endmodule : dfap_pin_model

// ---- test/test_dual_function_address_ports.sv ----
// self-checking bench for the dual-function address ports
`timescale 1ns/10ps
`include "dfap_defs.svh"
module test_dual_function_address_ports;
  import dfap_pkg::*;
  logic clock = 1'b0, srst = 1'b1, wr_en = 1'b0, rd_en = 1'b0;
  logic rd_n = 1'b1, wr_n = 1'b0, hold_ack = 1'b0, refresh_pulse = 1'b0;
  logic ext_wait_level, hold_request;
  dfap_addr_t addr = 4'h0;
  dfap_byte_t wdata = 8'h00, rdata, got;
  dfap_upper_addr_t ext_addr = 12'h9a5;
  dfap_byte_t fp_in, fp_out, fp_oe, fp_pu, sp_in, sp_out, sp_oe, sp_pu;
  dfap_byte_t fp_drv = 8'h3c, fp_en = 8'h00, sp_drv = 8'h00, sp_en = 8'h00;
  int errors = 0, samples_checked = 0, cycles = 0;
  initial forever #50 clock = ~clock;
  dfap_ports dfap_ports_inst (.clock(clock), .srst(srst), .addr(addr), .wdata(wdata),
    .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .ext_addr(ext_addr),
    .ext_rd_strobe_n(rd_n), .ext_wr_strobe_n(wr_n), .hold_ack(hold_ack),
    .refresh_pulse(refresh_pulse), .ext_wait_level(ext_wait_level),
    .hold_request(hold_request), .first_port_pin_in(fp_in), .first_port_pin_out(fp_out),
    .first_port_pin_oe(fp_oe), .first_port_pullup(fp_pu), .second_port_pin_in(sp_in),
    .second_port_pin_out(sp_out), .second_port_pin_oe(sp_oe), .second_port_pullup(sp_pu));
  dfap_pin_model fp_model_inst (.clock(clock), .pin_out(fp_out), .pin_oe(fp_oe),
    .pull_en(fp_pu), .ext_drv(fp_drv), .ext_en(fp_en), .pin_in(fp_in));
  dfap_pin_model sp_model_inst (.clock(clock), .pin_out(sp_out), .pin_oe(sp_oe),
    .pull_en(sp_pu), .ext_drv(sp_drv), .ext_en(sp_en), .pin_in(sp_in));
  // ============================================================
  // bus tasks and comparison
  task automatic wr(input dfap_addr_t a, input dfap_byte_t d);
    @(posedge clock);
    addr <= a;
    wdata <= d;
    wr_en <= 1'b1;
    @(posedge clock);
    wr_en <= 1'b0;
  endtask : wr
  task automatic rd(input dfap_addr_t a, output dfap_byte_t d);
    @(posedge clock);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge clock);
    rd_en <= 1'b0;
    @(negedge clock);
    d = rdata;
  endtask : rd
  task automatic chk(input dfap_byte_t g, input dfap_byte_t e, input string what);
    samples_checked++;
    if (g !== e) begin
      errors++;
      $display("unexpected at %0t: %s got %h want %h", $time, what, g, e);
    end
  endtask : chk
  task automatic settle(input int n);
    repeat (n) @(negedge clock);
  endtask : settle
  // ============================================================
  // scenarios
  task automatic reset_state;
    chk(fp_oe, 8'h00, "first oe at reset");
    chk(sp_oe, 8'h00, "second oe at reset");
    chk(fp_pu, 8'h00, "pull-up at reset");
  endtask : reset_state
  task automatic latch_and_direction;
    fp_en = 8'hff;
    wr(`DFAP_OFS_FP_DIR, 8'hf0);
    wr(`DFAP_OFS_FP_LATCH, 8'ha5);
    settle(6);
    chk(fp_oe, 8'h0f, "per-pin direction");
    chk(fp_out & 8'h0f, 8'h05, "output pins drive latch");
    rd(`DFAP_OFS_FP_LATCH, got);
    chk(got, 8'h35, "mixed read");
    wr(`DFAP_OFS_FP_DIR, 8'h00);
    settle(2);
    chk(fp_out, 8'ha5, "latch shows on switch to output");
    wr(`DFAP_OFS_FP_BSET, 8'h03);
    wr(`DFAP_OFS_FP_BCLR, 8'h00);
    rd(`DFAP_OFS_FP_LATCH, got);
    chk(got, 8'hac, "bit ops keep other bits");
    rd(4'h7, got);
    chk(got, 8'h00, "unmapped read");
  endtask : latch_and_direction
  task automatic pull_ups;
    wr(`DFAP_OFS_FP_DIR, 8'hf0);
    wr(`DFAP_OFS_PULLUP, 8'h01 << `DFAP_POS_FP_PULLUP);
    settle(2);
    chk(fp_pu, 8'hf0, "pull-up only on inputs");
    chk(sp_pu, 8'h00, "second-port pull-up stays off");
    wr(`DFAP_OFS_PULLUP, 8'h00);
    settle(2);
    chk(fp_pu, 8'h00, "pull-up off");
  endtask : pull_ups
  task automatic mode_table;
    dfap_mode_t codes[8] = '{4'h0, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'h8, 4'h9};
    dfap_byte_t fm[8] = '{8'h00, 8'h00, 8'h03, 8'h0f, 8'h3f, 8'hff, 8'h00, 8'h00};
    dfap_byte_t sm[8] = '{8'h00, 8'h00, 8'h30, 8'h30, 8'h30, 8'h30, 8'h33, 8'h3f};
    wr(`DFAP_OFS_FP_DIR, 8'hff);
    wr(`DFAP_OFS_SP_DIR, 8'hff);
    foreach (codes[i]) begin
      // address and strobes change every step so a stale copy is caught
      @(posedge clock);
      ext_addr <= ext_addr ^ 12'hfff;
      rd_n <= ~rd_n;
      wr_n <= ~wr_n;
      wr(`DFAP_OFS_MEM_MODE, {4'h0, codes[i]});
      settle(2);
      chk(fp_oe, fm[i], "first port address pins");
      chk(fp_out & fm[i], ext_addr[15:8] & fm[i], "upper address");
      chk(sp_oe, sm[i], "second port control pins");
      chk(sp_out & sm[i], {2'b00, wr_n, rd_n, ext_addr[19:16]} & sm[i],
          "address and strobes");
    end
    wr(`DFAP_OFS_MEM_MODE, 8'h00);
  endtask : mode_table
  task automatic control_pins;
    sp_en = 8'h40;
    sp_drv = 8'h40;
    wr(`DFAP_OFS_BUS_CTRL, 8'h01 << `DFAP_POS_HOLD_EN);
    hold_ack <= 1'b1;
    settle(6);
    chk({7'h00, hold_request}, 8'h01, "hold request follows pin");
    chk(sp_oe & sp_out & 8'hc0, 8'h80, "hold acknowledge out");
    @(posedge clock);
    hold_ack <= 1'b0;
    refresh_pulse <= 1'b1;
    sp_drv = 8'h00;
    wr(`DFAP_OFS_BUS_CTRL, 8'h05);
    settle(6);
    chk({7'h00, ext_wait_level}, 8'h00, "wait follows pin");
    chk(sp_oe & sp_out & 8'hc0, 8'h80, "refresh pulse out");
    chk({7'h00, hold_request}, 8'h00, "no hold request without enable");
    @(posedge clock);
    refresh_pulse <= 1'b0;
    settle(2);
    chk(sp_out & 8'h80, 8'h00, "refresh pulse low");
  endtask : control_pins
  // ============================================================
  // run control
  task automatic wrap_up;
    $display("comparisons %0d, mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : wrap_up
  always @(posedge clock) begin
    cycles++;
    if (cycles == 20000) begin
      errors++;
      wrap_up();
    end
  end
  initial begin
    repeat (8) @(posedge clock);
    srst <= 1'b0;
    settle(1);
    reset_state();
    latch_and_direction();
    pull_ups();
    mode_table();
    control_pins();
    wrap_up();
  end
endmodule : test_dual_function_address_ports
